// ==== core/nfc_pkg.sv ====
// Purpose: constants and types of the filter coefficient / nvm register bank
// Assumes: register index times four is the apb byte address
// Notes:   all timing counts derive from the 250 MHz clock
package nfc_pkg;
    localparam int          ENTRIES          = 12;
    localparam logic [7:0]  IDX_CHECKSUM     = 8'h2B;
    localparam logic [7:0]  IDX_NVM_CONTROL  = 8'h40;
    localparam logic [7:0]  IDX_BP_A2_HIGH   = 8'h41;
    localparam logic [7:0]  IDX_BP_A2_LOW    = 8'h42;
    localparam logic [7:0]  IDX_BP_A3_HIGH   = 8'h43;
    localparam logic [7:0]  IDX_BP_A3_LOW    = 8'h44;
    localparam logic [7:0]  IDX_BP_B1_HIGH   = 8'h45;
    localparam logic [7:0]  IDX_BP_B1_LOW    = 8'h46;
    localparam logic [7:0]  IDX_LP_A2_HIGH   = 8'h47;
    localparam logic [7:0]  IDX_LP_A2_LOW    = 8'h48;
    localparam logic [7:0]  IDX_LP_B1_HIGH   = 8'h49;
    localparam logic [7:0]  IDX_LP_B1_LOW    = 8'h4A;
    localparam logic [7:0]  IDX_TEST_SELECT  = 8'h4B;
    localparam logic [7:0]  IDX_IRQ_STATUS   = 8'h50;
    localparam logic [7:0]  IDX_IRQ_MASK     = 8'h51;
    // entry order of the image kept in nvm
    localparam logic [7:0]  ENTRY_INDEX [ENTRIES] = '{
        IDX_CHECKSUM, IDX_BP_A2_HIGH, IDX_BP_A2_LOW, IDX_BP_A3_HIGH, IDX_BP_A3_LOW,
        IDX_BP_B1_HIGH, IDX_BP_B1_LOW, IDX_LP_A2_HIGH, IDX_LP_A2_LOW,
        IDX_LP_B1_HIGH, IDX_LP_B1_LOW, IDX_TEST_SELECT};
    localparam logic [7:0]  ENTRY_WMASK [ENTRIES] = '{
        8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'h7F, 8'hFF, 8'h7F, 8'hFF, 8'hEF};
    localparam logic [7:0]  ENTRY_RESET      = 8'h00;
    localparam int          E_LP_A2_HIGH     = 7;
    localparam int          E_LP_B1_HIGH     = 9;
    localparam int          E_TEST_SELECT    = 11;
    // nvm_control fields
    localparam int          CTL_PROGRAM      = 0;
    localparam int          CTL_RELOAD       = 1;
    localparam int          CTL_SUCCESS      = 2;
    localparam int          CTL_UNLOCK_LSB   = 3;
    localparam int          CTL_DUMP         = 7;
    localparam logic [3:0]  UNLOCK_CODE      = 4'hD;
    // test_signal_select fields
    localparam int          TS_SAMPLE_SEL    = 3;
    localparam int          TS_SOURCE_LSB    = 0;
    // interrupt status / mask bits
    localparam int          IRQ_WIDTH        = 3;
    localparam int          IRQ_PROGRAM_OK   = 0;
    localparam int          IRQ_PROGRAM_FAIL = 1;
    localparam int          IRQ_RELOAD_DONE  = 2;
    // timing
    localparam int          CLOCK_PERIOD_PS  = 4000;
    localparam int          SAMPLE_8BIT_NS   = 1000;
    localparam int          SAMPLE_12BIT_NS  = 2000;
    localparam int          PROGRAM_NS       = 8000;
    localparam int          CNT_WIDTH        = 11;
    localparam logic [CNT_WIDTH-1:0] SAMPLE_8BIT_CYCLES  =
        CNT_WIDTH'(SAMPLE_8BIT_NS * 1000 / CLOCK_PERIOD_PS);
    localparam logic [CNT_WIDTH-1:0] SAMPLE_12BIT_CYCLES =
        CNT_WIDTH'(SAMPLE_12BIT_NS * 1000 / CLOCK_PERIOD_PS);
    localparam logic [CNT_WIDTH-1:0] PROGRAM_CYCLES      =
        CNT_WIDTH'((PROGRAM_NS * 1000 + CLOCK_PERIOD_PS - 1) / CLOCK_PERIOD_PS);

    typedef enum logic [2:0] {
        SRC_OFF       = 3'h0,
        SRC_LOWPASS   = 3'h1,
        SRC_RECTIFIER = 3'h2,
        SRC_BANDPASS  = 3'h3,
        SRC_CONVERTER = 3'h4
    } nfc_source_t;

    typedef enum logic [1:0] {NVM_IDLE, NVM_PROGRAM, NVM_RELOAD} nfc_nvm_state_t;

    typedef struct packed {
        logic [15:0] bp_a2;
        logic [15:0] bp_a3;
        logic [15:0] bp_b1;
        logic [15:0] lp_a2;
        logic [15:0] lp_b1;
    } nfc_coeff_t;

    typedef struct packed {
        logic       dump_enable;
        logic       sample_12bit;
        logic [2:0] source;
    } nfc_path_t;
endpackage : nfc_pkg

// ==== core/nfc_regs.sv ====
// Purpose: apb register bank for nvm control, filter coefficients and test select
// Assumes: apb3 master, byte address = register index * 4, 12-bit address
// Notes:   one wait-free access cycle; status read clears the interrupt flags
//
// Overview of operation
// - nvm programming is accepted only while the unlock field 6:3 holds 0xD.
// - writing one to control bit 0 programs the register image into the nvm.
// - writing one to control bit 1 reloads the configuration registers from the nvm; here only when bit 0 is written zero in the same write.
// - control bit 2 reads one after a successful program and zero otherwise.
// - control bit 7 is the dump enable, writable by software and cleared by hardware.
// - an eight-bit read/write checksum register resets to zero.
// - bandpass a2, a3 and b1 are high/low byte read/write pairs resetting to zero.
// - lowpass a2 and b1 high bytes hold bits 6:0 only, bit 7 reads zero.
// - sample select zero gives 8-bit samples each 1 us, one gives 12-bit each 2 us.
// - source field 2:0 picks off, lowpass, rectifier, bandpass or converter; others idle.
//
// The implementer's own choice: register access over APB.
`timescale 1ns/1ps
`default_nettype none
module nfc_regs (
    input  wire logic               i_clock,
    input  wire logic               i_rst_b,
    input  wire logic               i_psel,
    input  wire logic               i_penable,
    input  wire logic               i_pwrite,
    input  wire logic [11:0]        i_paddr,
    input  wire logic [31:0]        i_pwdata,
    input  wire logic               i_dump_done,
    input  wire logic               i_program_fault,
    output logic [31:0]             o_prdata,
    output logic                    o_pready,
    output logic                    o_pslverr,
    output nfc_pkg::nfc_coeff_t     o_coeff,
    output nfc_pkg::nfc_path_t      o_path,
    output logic                    o_sample_strobe,
    output logic                    o_nvm_busy,
    output logic                    o_irq
);
    logic [7:0]                      cfg [nfc_pkg::ENTRIES];
    logic [7:0]                      nvm [nfc_pkg::ENTRIES];
    nfc_pkg::nfc_nvm_state_t         state;
    logic [nfc_pkg::CNT_WIDTH-1:0]   prog_count;
    logic [nfc_pkg::CNT_WIDTH-1:0]   sample_count;
    logic                            fault_seen;
    logic                            ctl_dump;
    logic [3:0]                      ctl_unlock;
    logic                            ctl_success;
    logic [nfc_pkg::IRQ_WIDTH-1:0]   irq_status;
    logic [nfc_pkg::IRQ_WIDTH-1:0]   irq_mask;
    logic [nfc_pkg::IRQ_WIDTH-1:0]   irq_event;
    logic [9:0]                      index;
    logic                            addr_ok;
    logic                            access;
    logic                            wr_en;
    logic                            ctl_wr;
    logic                            status_rd;
    logic                            start_program;
    logic                            refuse_program;
    logic                            start_reload;
    logic                            program_last;
    logic                            path_live;
    logic [nfc_pkg::CNT_WIDTH-1:0]   sample_last;
    logic [31:0]                     next_prdata;
    logic                            next_pslverr;

    assign index    = i_paddr[11:2];
    assign access   = i_psel && i_penable && o_pready;
    assign wr_en    = access && i_pwrite && !o_pslverr;
    assign ctl_wr   = wr_en && index == {2'b00, nfc_pkg::IDX_NVM_CONTROL};
    assign status_rd = access && !i_pwrite && !o_pslverr
                       && index == {2'b00, nfc_pkg::IDX_IRQ_STATUS};
    assign program_last = state == nfc_pkg::NVM_PROGRAM
                          && prog_count == nfc_pkg::PROGRAM_CYCLES - 1'b1;
    // triggers are ignored while an nvm operation is running
    assign start_program  = ctl_wr && i_pwdata[nfc_pkg::CTL_PROGRAM]
                            && state == nfc_pkg::NVM_IDLE
                            && ctl_unlock == nfc_pkg::UNLOCK_CODE;
    assign refuse_program = ctl_wr && i_pwdata[nfc_pkg::CTL_PROGRAM]
                            && state == nfc_pkg::NVM_IDLE
                            && ctl_unlock != nfc_pkg::UNLOCK_CODE;
    assign start_reload   = ctl_wr && i_pwdata[nfc_pkg::CTL_RELOAD]
                            && !i_pwdata[nfc_pkg::CTL_PROGRAM]
                            && state == nfc_pkg::NVM_IDLE;
    assign irq_event = {state == nfc_pkg::NVM_RELOAD,
                        refuse_program || (program_last && (fault_seen || i_program_fault)),
                        program_last && !(fault_seen || i_program_fault)};

    // per-entry storage, nvm image and its copy paths
    for (genvar g = 0; g < nfc_pkg::ENTRIES; g++) begin : g_entry
        always_ff @(posedge i_clock or negedge i_rst_b) begin
            if (!i_rst_b) begin
                cfg[g] <= nfc_pkg::ENTRY_RESET;
            end else if (state == nfc_pkg::NVM_RELOAD) begin
                cfg[g] <= nvm[g] & nfc_pkg::ENTRY_WMASK[g];
            end else if (wr_en && index == {2'b00, nfc_pkg::ENTRY_INDEX[g]}) begin
                cfg[g] <= i_pwdata[7:0] & nfc_pkg::ENTRY_WMASK[g];
            end
        end
        // blank cells read as zero after reset
        always_ff @(posedge i_clock or negedge i_rst_b) begin
            if (!i_rst_b) begin
                nvm[g] <= nfc_pkg::ENTRY_RESET;
            end else if (program_last && !(fault_seen || i_program_fault)) begin
                nvm[g] <= cfg[g];
            end
        end
    end

    // nvm sequencer
    always_ff @(posedge i_clock or negedge i_rst_b) begin
        if (!i_rst_b) begin
            state      <= nfc_pkg::NVM_IDLE;
            prog_count <= '0;
            fault_seen <= 1'b0;
        end else begin
            unique case (state)
                nfc_pkg::NVM_IDLE: begin
                    prog_count <= '0;
                    fault_seen <= 1'b0;
                    if (start_program) begin
                        state <= nfc_pkg::NVM_PROGRAM;
                    end else if (start_reload) begin
                        state <= nfc_pkg::NVM_RELOAD;
                    end
                end
                nfc_pkg::NVM_PROGRAM: begin
                    prog_count <= prog_count + 1'b1;
                    fault_seen <= fault_seen || i_program_fault;
                    if (program_last) begin
                        state <= nfc_pkg::NVM_IDLE;
                    end
                end
                nfc_pkg::NVM_RELOAD: begin
                    state <= nfc_pkg::NVM_IDLE;
                end
            endcase
        end
    end

    // control register fields other than the triggers
    always_ff @(posedge i_clock or negedge i_rst_b) begin
        if (!i_rst_b) begin
            ctl_dump    <= 1'b0;
            ctl_unlock  <= 4'h0;
            ctl_success <= 1'b0;
        end else begin
            if (ctl_wr) begin
                ctl_dump   <= i_pwdata[nfc_pkg::CTL_DUMP];
                ctl_unlock <= i_pwdata[nfc_pkg::CTL_UNLOCK_LSB +: 4];
            end else if (i_dump_done) begin
                ctl_dump <= 1'b0;
            end
            if (start_program) begin
                ctl_success <= 1'b0;
            end else if (program_last) begin
                ctl_success <= !(fault_seen || i_program_fault);
            end
        end
    end

    // interrupt flags: a new event outranks the read that clears
    always_ff @(posedge i_clock or negedge i_rst_b) begin
        if (!i_rst_b) begin
            irq_status <= '0;
            irq_mask   <= '0;
            o_irq      <= 1'b0;
        end else begin
            irq_status <= (status_rd ? '0 : irq_status) | irq_event;
            if (wr_en && index == {2'b00, nfc_pkg::IDX_IRQ_MASK}) begin
                irq_mask <= i_pwdata[nfc_pkg::IRQ_WIDTH-1:0];
            end
            o_irq <= |(irq_status & irq_mask);
        end
    end

    // sample strobe for the selected data path
    assign path_live = cfg[nfc_pkg::E_TEST_SELECT][2:0] >= 3'(nfc_pkg::SRC_LOWPASS)
                    && cfg[nfc_pkg::E_TEST_SELECT][2:0] <= 3'(nfc_pkg::SRC_CONVERTER);
    assign sample_last = cfg[nfc_pkg::E_TEST_SELECT][nfc_pkg::TS_SAMPLE_SEL]
                         ? nfc_pkg::SAMPLE_12BIT_CYCLES - 1'b1
                         : nfc_pkg::SAMPLE_8BIT_CYCLES - 1'b1;
    always_ff @(posedge i_clock or negedge i_rst_b) begin
        if (!i_rst_b) begin
            sample_count    <= '0;
            o_sample_strobe <= 1'b0;
        end else if (!path_live) begin
            sample_count    <= '0;
            o_sample_strobe <= 1'b0;
        end else if (sample_count >= sample_last) begin
            sample_count    <= '0;
            o_sample_strobe <= 1'b1;
        end else begin
            sample_count    <= sample_count + 1'b1;
            o_sample_strobe <= 1'b0;
        end
    end

    // read mux, captured in the setup cycle
    always_comb begin
        next_prdata  = 32'h0000_0000;
        next_pslverr = 1'b0;
        addr_ok      = 1'b0;
        for (int k = 0; k < nfc_pkg::ENTRIES; k++) begin
            if (index == {2'b00, nfc_pkg::ENTRY_INDEX[k]}) begin
                next_prdata[7:0] = cfg[k];
                addr_ok          = 1'b1;
            end
        end
        if (index == {2'b00, nfc_pkg::IDX_NVM_CONTROL}) begin
            next_prdata[7:0] = {ctl_dump, ctl_unlock, ctl_success,
                                state == nfc_pkg::NVM_RELOAD,
                                state == nfc_pkg::NVM_PROGRAM};
            addr_ok          = 1'b1;
        end else if (index == {2'b00, nfc_pkg::IDX_IRQ_STATUS}) begin
            next_prdata[nfc_pkg::IRQ_WIDTH-1:0] = irq_status;
            addr_ok                             = 1'b1;
        end else if (index == {2'b00, nfc_pkg::IDX_IRQ_MASK}) begin
            next_prdata[nfc_pkg::IRQ_WIDTH-1:0] = irq_mask;
            addr_ok                             = 1'b1;
        end
        if (!addr_ok) begin
            next_pslverr = 1'b1;
            next_prdata  = 32'h0000_0000;
        end
    end

    always_ff @(posedge i_clock or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_pready  <= 1'b0;
            o_pslverr <= 1'b0;
            o_prdata  <= 32'h0000_0000;
        end else begin
            o_pready  <= i_psel && !i_penable;
            o_pslverr <= i_psel && !i_penable && next_pslverr;
            o_prdata  <= (i_psel && !i_penable && !i_pwrite) ? next_prdata : 32'h0000_0000;
        end
    end

    always_ff @(posedge i_clock or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_nvm_busy <= 1'b0;
        end else begin
            o_nvm_busy <= start_program || start_reload
                          || (state == nfc_pkg::NVM_PROGRAM && !program_last);
        end
    end

    assign o_coeff = {cfg[1], cfg[2], cfg[3], cfg[4], cfg[5], cfg[6],
                      cfg[7], cfg[8], cfg[9], cfg[10]};
    assign o_path  = {ctl_dump, cfg[nfc_pkg::E_TEST_SELECT][nfc_pkg::TS_SAMPLE_SEL],
                      cfg[nfc_pkg::E_TEST_SELECT][nfc_pkg::TS_SOURCE_LSB +: 3]};

    // independent watch on program length, apart from the sequencer's own counter
    logic [nfc_pkg::CNT_WIDTH:0]     prog_watch;
    always_ff @(posedge i_clock or negedge i_rst_b) begin
        if (!i_rst_b) begin
            prog_watch <= '0;
        end else if (state == nfc_pkg::NVM_PROGRAM) begin
            prog_watch <= prog_watch + 1'b1;
        end else begin
            prog_watch <= '0;
        end
    end

    default clocking cb @(posedge i_clock); endclocking
    default disable iff (!i_rst_b);

    a_unlock_gates_prog: assert property ($rose(state == nfc_pkg::NVM_PROGRAM)
        |-> $past(ctl_unlock) == nfc_pkg::UNLOCK_CODE)
        else $error("program started while locked");
    a_refused_program: assert property (refuse_program
        |=> state == nfc_pkg::NVM_IDLE && irq_status[nfc_pkg::IRQ_PROGRAM_FAIL])
        else $error("locked program not refused");
    // a hung program is caught by the bound, a short one by the length
    a_program_ends: assert property (state == nfc_pkg::NVM_PROGRAM
        |-> prog_watch < {1'b0, nfc_pkg::PROGRAM_CYCLES})
        else $error("program did not finish in time");
    a_program_length: assert property ($fell(state == nfc_pkg::NVM_PROGRAM)
        |-> prog_watch == {1'b0, nfc_pkg::PROGRAM_CYCLES})
        else $error("program length wrong");
    a_program_busy: assert property (state == nfc_pkg::NVM_PROGRAM
        && !program_last
        |-> o_nvm_busy)
        else $error("busy low while programming");
    a_nvm_copy: assert property (program_last
        && !(fault_seen || i_program_fault)
        |=> nvm[0] == $past(cfg[0]))
        else $error("program did not copy register data");
    a_reload_copies: assert property (state == nfc_pkg::NVM_RELOAD
        |=> cfg[1] == $past(nvm[1]) && state == nfc_pkg::NVM_IDLE)
        else $error("reload did not copy nvm data");
    a_success_reports: assert property (program_last
        |=> ctl_success == !($past(fault_seen) || $past(i_program_fault)))
        else $error("program status wrong");
    a_success_cleared: assert property (start_program |=> !ctl_success)
        else $error("success bit not cleared at program start");
    a_fault_keeps_nvm: assert property (program_last
        && (fault_seen || i_program_fault)
        |=> $stable(nvm[0]))
        else $error("failed program changed nvm");
    a_dump_hw_clear: assert property (i_dump_done && !ctl_wr |=> !ctl_dump)
        else $error("dump enable not cleared by hardware");
    a_dump_write_wins: assert property (ctl_wr
        |=> ctl_dump == $past(i_pwdata[nfc_pkg::CTL_DUMP]))
        else $error("dump enable write lost");
    a_checksum_write: assert property (wr_en && index == 10'h02B
        && state != nfc_pkg::NVM_RELOAD |=> cfg[0] == $past(i_pwdata[7:0]))
        else $error("checksum write lost");
    a_bandpass_write: assert property (wr_en && index == 10'h043
        && state != nfc_pkg::NVM_RELOAD |=> o_coeff.bp_a3[15:8] == $past(i_pwdata[7:0]))
        else $error("bandpass byte write lost");
    a_lowpass_msb_zero: assert property (!cfg[nfc_pkg::E_LP_A2_HIGH][7]
        && !cfg[nfc_pkg::E_LP_B1_HIGH][7])
        else $error("lowpass high byte bit 7 set");
    a_lowpass_write: assert property (wr_en && index == 10'h049
        && state != nfc_pkg::NVM_RELOAD
        |=> cfg[nfc_pkg::E_LP_B1_HIGH] == {1'b0, $past(i_pwdata[6:0])})
        else $error("lowpass high byte write wrong");
    a_sample_spacing: assert property (o_sample_strobe && $stable(o_path)
        |-> ##1 !o_sample_strobe [*8])
        else $error("sample strobes too close");
    a_unused_src_quiet: assert property (!path_live ##1 !path_live
        |-> !o_sample_strobe)
        else $error("strobe with idle source");
    a_reserved_reads_0: assert property (o_pready && !i_pwrite
        && index == 10'h04B |-> o_prdata[31:8] == 24'h000000 && !o_prdata[4])
        else $error("reserved bits read nonzero");
    a_test_rsvd_zero: assert property (!cfg[nfc_pkg::E_TEST_SELECT][4])
        else $error("test select reserved bit set");
    a_unmapped_err: assert property (o_pready && o_pslverr
        |-> o_prdata == 32'h0000_0000)
        else $error("unmapped read returned data");
    a_status_sticky: assert property (|irq_event
        |=> (irq_status & $past(irq_event)) == $past(irq_event))
        else $error("interrupt event lost");
    a_irq_level: assert property (|(irq_status & irq_mask) |=> o_irq)
        else $error("interrupt output low with unmasked status");

    c_program_ok: cover property (program_last && !fault_seen && !i_program_fault);
    c_reload: cover property (state == nfc_pkg::NVM_RELOAD);
    c_wide_sample: cover property (o_sample_strobe && o_path.sample_12bit);
    c_refused: cover property (refuse_program);
    c_dump_clear: cover property (i_dump_done && ctl_dump && !ctl_wr);
endmodule : nfc_regs
`default_nettype wire

// ==== dv/tb_top.sv ====
// Purpose: self-checking apb bench for the nvm / filter coefficient register bank
// Assumes: one access cycle per apb transfer, program takes 2000 cycles
// Notes:   all expectations derive from the register table and package constants
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    logic                i_clock;
    logic                i_rst_b;
    logic                psel;
    logic                penable;
    logic                pwrite;
    logic [11:0]         paddr;
    logic [31:0]         pwdata;
    logic                dump_done;
    logic                program_fault;
    logic [31:0]         prdata;
    logic                pready;
    logic                pslverr;
    nfc_pkg::nfc_coeff_t coeff;
    nfc_pkg::nfc_path_t  path;
    logic                strobe;
    logic                busy;
    logic                irq;
    int                  miscompares;
    int                  check_count;
    logic [31:0]         rdata;
    logic                rerr;

    nfc_regs nfc_regs_i (
        .i_clock(i_clock), .i_rst_b(i_rst_b), .i_psel(psel), .i_penable(penable),
        .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .i_dump_done(dump_done),
        .i_program_fault(program_fault), .o_prdata(prdata), .o_pready(pready),
        .o_pslverr(pslverr), .o_coeff(coeff), .o_path(path), .o_sample_strobe(strobe),
        .o_nvm_busy(busy), .o_irq(irq));

    initial begin
        i_clock = 1'b0;
        forever #2 i_clock = ~i_clock;
    end

    task automatic report_and_stop;
        $display("checks %0d, mismatches %0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : report_and_stop

    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        check_count++;
        if (got !== exp) begin
            miscompares++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk

    // one transfer, then one idle edge so no signal is driven twice per step
    task automatic apb(input logic w, input logic [7:0] idx, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= {2'h0, idx, 2'h0};
        pwdata <= d;
        @(posedge i_clock);
        penable <= 1'b1;
        // no limit here: a hung transfer is ended by the watchdog
        do begin
            @(posedge i_clock);
        end while (pready !== 1'b1);
        rdata = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge i_clock);
    endtask : apb

    task automatic rd(input logic [7:0] idx, input logic [31:0] exp, input string nm);
        apb(1'b0, idx, 32'h0000_0000);
        chk(nm, exp, rdata);
    endtask : rd

    task automatic wait_idle;
        int n;
        n = 0;
        do begin
            @(posedge i_clock);
            n++;
        end while (busy !== 1'b0 && n < 3000);
        chk("nvm busy", 32'h0, {31'h0, busy});
    endtask : wait_idle

    // gap between two strobes, in clock edges
    task automatic strobe_gap(input int exp, input string nm);
        int n;
        n = 0;
        do begin
            @(posedge i_clock);
            n++;
        end while (strobe !== 1'b1 && n < 1200);
        n = 0;
        do begin
            @(posedge i_clock);
            n++;
        end while (strobe !== 1'b1 && n < 1200);
        chk(nm, exp, n);
    endtask : strobe_gap

    initial begin
        #160000;
        miscompares++;
        report_and_stop();
    end

    initial begin
        int cnt;
        {psel, penable, pwrite, paddr, pwdata, dump_done, program_fault} = '0;
        miscompares = 0;
        check_count = 0;
        i_rst_b = 1'b0;
        repeat (8) @(posedge i_clock);
        i_rst_b <= 1'b1;
        @(posedge i_clock);
        for (int i = 0; i < nfc_pkg::ENTRIES; i++) begin
            rd(nfc_pkg::ENTRY_INDEX[i], 32'h0, "entry reset");
        end
        rd(nfc_pkg::IDX_NVM_CONTROL, 32'h0, "control reset");
        // full-ones pattern exposes every reserved bit
        for (int i = 0; i < nfc_pkg::ENTRIES; i++) begin
            apb(1'b1, nfc_pkg::ENTRY_INDEX[i], 32'h0000_00FF);
            rd(nfc_pkg::ENTRY_INDEX[i], {24'h0, nfc_pkg::ENTRY_WMASK[i]}, "entry mask");
        end
        chk("lp a2 out", 32'h7FFF, {16'h0, coeff.lp_a2});
        chk("bp b1 out", 32'hFFFF, {16'h0, coeff.bp_b1});
        apb(1'b0, 8'h30, 32'h0);
        chk("unmapped err", 32'h1, {31'h0, rerr});
        chk("unmapped data", 32'h0, rdata);
        apb(1'b1, nfc_pkg::IDX_IRQ_MASK, 32'h0000_0007);
        apb(1'b1, nfc_pkg::IDX_NVM_CONTROL, 32'h0000_0001);
        rd(nfc_pkg::IDX_NVM_CONTROL, 32'h0, "locked program");
        chk("irq raised", 32'h1, {31'h0, irq});
        rd(nfc_pkg::IDX_IRQ_STATUS, 32'h2, "refused status");
        repeat (3) @(posedge i_clock);
        chk("irq cleared", 32'h0, {31'h0, irq});
        apb(1'b1, nfc_pkg::IDX_NVM_CONTROL, 32'h0000_0080);
        chk("dump out", 32'h1, {31'h0, path.dump_enable});
        dump_done <= 1'b1;
        @(posedge i_clock);
        dump_done <= 1'b0;
        rd(nfc_pkg::IDX_NVM_CONTROL, 32'h0, "dump cleared");
        apb(1'b1, nfc_pkg::IDX_NVM_CONTROL, 32'h0000_0068);
        apb(1'b1, nfc_pkg::IDX_NVM_CONTROL, 32'h0000_0069);
        chk("program busy", 32'h1, {31'h0, busy});
        rd(nfc_pkg::IDX_NVM_CONTROL, 32'h69, "programming");
        wait_idle();
        rd(nfc_pkg::IDX_NVM_CONTROL, 32'h6C, "program ok");
        rd(nfc_pkg::IDX_IRQ_STATUS, 32'h1, "ok status");
        apb(1'b1, nfc_pkg::IDX_BP_A2_HIGH, 32'h0000_0012);
        apb(1'b1, nfc_pkg::IDX_LP_B1_LOW, 32'h0000_0034);
        apb(1'b1, nfc_pkg::IDX_NVM_CONTROL, 32'h0000_006A);
        wait_idle();
        rd(nfc_pkg::IDX_BP_A2_HIGH, 32'hFF, "reload high");
        rd(nfc_pkg::IDX_LP_B1_LOW, 32'hFF, "reload low");
        rd(nfc_pkg::IDX_IRQ_STATUS, 32'h4, "reload status");
        apb(1'b1, nfc_pkg::IDX_IRQ_MASK, 32'h0000_0000);
        apb(1'b1, nfc_pkg::IDX_NVM_CONTROL, 32'h0000_0069);
        program_fault <= 1'b1;
        @(posedge i_clock);
        program_fault <= 1'b0;
        wait_idle();
        chk("irq masked", 32'h0, {31'h0, irq});
        rd(nfc_pkg::IDX_NVM_CONTROL, 32'h68, "program fail");
        rd(nfc_pkg::IDX_IRQ_STATUS, 32'h2, "fail status");
        for (int s = 1; s <= 4; s++) begin
            apb(1'b1, nfc_pkg::IDX_TEST_SELECT, s);
            chk("source out", s, {29'h0, path.source});
            strobe_gap(250, "8bit gap");
        end
        apb(1'b1, nfc_pkg::IDX_TEST_SELECT, 32'h0000_000B);
        chk("12bit out", 32'h1, {31'h0, path.sample_12bit});
        strobe_gap(500, "12bit gap");
        // off code 0 and unused code 5 must stay silent
        for (int s = 0; s <= 5; s += 5) begin
            apb(1'b1, nfc_pkg::IDX_TEST_SELECT, s);
            cnt = 0;
            repeat (600) begin
                @(posedge i_clock);
                cnt += int'(strobe === 1'b1);
            end
            chk("no strobe", 32'h0, cnt);
        end
        report_and_stop();
    end
endmodule : tb_top
`default_nettype wire
